// ==== verilog/fp_regs.vh ====
// Register offsets, reset values and timing constants for the
// front-panel status sequencer. Definitions only.
`ifndef FP_REGS_VH
`define FP_REGS_VH

// APB register byte offsets
`define FP_CTRL_OFS      8'h00
`define FP_STATE_OFS     8'h04
`define FP_IRQ_STAT_OFS  8'h08
`define FP_IRQ_EN_OFS    8'h0C
`define FP_IRQ_CLR_OFS   8'h10

// Reset values
`define FP_CTRL_RST      1'h0
`define FP_IRQ_EN_RST    6'h00

// CTRL field: software stop request
`define FP_CTRL_STOP_BIT 0

// Event bits, same layout in status, enable and clear
`define FP_EV_READY      0
`define FP_EV_STOPPED    1
`define FP_EV_CLASS1     2
`define FP_EV_CLASS2     3
`define FP_EV_START_FLT  4
`define FP_EV_HEAD_FAIL  5
`define FP_EV_W          6

// Timing
`define FP_CLK_HZ        125000000
`define FP_SPINUP_S      60
`define FP_SLOW_MS       1000
`define FP_FAST_MS       500
`define FP_HALF_FAST     26'h1DCD650

`endif

// ==== verilog/fp_sync.v ====
// Two-flop synchroniser for a vector of pin inputs.
// Assumes each bit is a slow level from outside the mclk domain.
`timescale 1ns/1ps
module fp_sync #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  // First stage feeds the second stage only
  always @(posedge mclk)
  begin
    if (rst)
    begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ==== verilog/fp_blink.v ====
// Free-running blink generator: a fast and a slow square wave.
// Assumes one clock; the slow wave toggles on every second fast toggle.
`timescale 1ns/1ps
module fp_blink #(
  parameter       CW        = 26,
  parameter [CW-1:0] HALF_FAST = 26'd31250000
) (
  input  wire mclk,
  input  wire rst,
  output reg  fast,
  output reg  slow
);

  reg [CW-1:0] cnt;

  always @(posedge mclk)
  begin
    if (rst)
    begin
      cnt  <= {CW{1'b0}};
      fast <= 1'b0;
      slow <= 1'b0;
    end
    else if (cnt == HALF_FAST - 1'b1)
    begin
      cnt  <= {CW{1'b0}};
      fast <= ~fast;
      if (fast)
        slow <= ~slow;
    end
    else
      cnt <= cnt + 1'b1;
  end

endmodule

// ==== verilog/front_panel_status_sequencer.v ====
// Front-panel status and interlock sequencer with APB registers.
// Assumes all panel and drive-interface inputs are asynchronous levels;
// APB comes from logic on mclk.
//
// Notes on behaviour
// - Commands ignored until ready
// - Steady green only when fully ready
// - Green blinks during start and stop
// - Class one fault: steady red, restore clears
// - Class two fault: blink red, shutdown clears
// - Head retract failure: stop, both blink, locked
// - Cartridge tab removed blocks cartridge writes
// - Fixed protect switch blocks fixed writes
// - Idle keeps both indicators dark
// - No cartridge seated or door open, with DC power on: blink red, no spin
// - Run off clears start fault, retry allowed
// - One-second blink during spin-up, then steady
// - Half-second blink during stop, then dark
// - Spin-up needs all start conditions true
// - Spin-up cycle lasts about sixty seconds
// - Spin request drop or run off stops
// - Panel stop waits for write gate
`timescale 1ns/1ps
`include "fp_regs.vh"
module front_panel_status_sequencer #(
  parameter [63:0] SPINUP_CYCLES = 64'd`FP_SPINUP_S * 64'd`FP_CLK_HZ,
  parameter [25:0] HALF_FAST     = `FP_HALF_FAST
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  input  wire        run_sw,
  input  wire        cart_seated,
  input  wire        door_closed,
  input  wire        dc_power,
  input  wire        spindle_on,
  input  wire        power_safe,
  input  wire        write_gate,
  input  wire        cart_protect,
  input  wire        fixed_protect,
  input  wire        cart_addressed,
  input  wire        spindle_stopped,
  input  wire        head_retract_fail,
  input  wire        class1_fault,
  input  wire        class2_fault,
  input  wire        restore,
  input  wire        cmd_strobe,
  output reg         ready_led,
  output reg         fault_led,
  output reg         door_lock,
  output reg         spindle_run,
  output reg         drive_ready,
  output reg         cmd_accept,
  output reg         write_enable
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_SFLT  = 6'h02;
  localparam [5:0] S_SPUP  = 6'h04;
  localparam [5:0] S_READY = 6'h08;
  localparam [5:0] S_SPDN  = 6'h10;
  localparam [5:0] S_HEAD  = 6'h20;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  wire [15:0] pins_s;
  fp_sync #(
    .W (16)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({cmd_strobe, restore, class2_fault, class1_fault,
            head_retract_fail, spindle_stopped, cart_addressed,
            fixed_protect, cart_protect, write_gate, power_safe,
            spindle_on, dc_power, door_closed, cart_seated, run_sw}),
    .q    (pins_s)
  );

  wire run_s    = pins_s[0];
  wire seat_s   = pins_s[1];
  wire door_s   = pins_s[2];
  wire dcp_s    = pins_s[3];
  wire spon_s   = pins_s[4];
  wire psafe_s  = pins_s[5];
  wire wg_s     = pins_s[6];
  wire cprot_s  = pins_s[7];
  wire fprot_s  = pins_s[8];
  wire csel_s   = pins_s[9];
  wire stop_s   = pins_s[10];
  wire hfail_s  = pins_s[11];
  wire c1_s     = pins_s[12];
  wire c2_s     = pins_s[13];
  wire rest_s   = pins_s[14];
  wire cmd_s    = pins_s[15];

  // ----------------------------------------------------------------
  // Blink source
  // ----------------------------------------------------------------
  wire blink_fast;
  wire blink_slow;
  fp_blink #(
    .CW        (26),
    .HALF_FAST (HALF_FAST)
  ) u_blink (
    .mclk (mclk),
    .rst  (rst),
    .fast (blink_fast),
    .slow (blink_slow)
  );

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  reg [5:0]  state;
  reg [5:0]  next_state;
  reg [63:0] spin_cnt;
  reg        sw_stop;
  reg        c1_flag;
  reg        c2_flag;
  reg        rest_d;
  reg        cmd_d;
  reg [`FP_EV_W-1:0] irq_stat;
  reg [`FP_EV_W-1:0] irq_en;

  wire start_ok  = seat_s & door_s & dcp_s & spon_s & psafe_s;
  wire spinning  = (state == S_SPUP) | (state == S_READY);
  wire panel_off = ~run_s | sw_stop;
  wire rest_edge = rest_s & ~rest_d;
  wire cmd_edge  = cmd_s & ~cmd_d;
  wire spun_up   = (spin_cnt == SPINUP_CYCLES - 64'd1);

  always @*
  begin
    next_state = state;
    case (state)
      S_IDLE:
      begin
        if (run_s & ~sw_stop & start_ok)
          next_state = S_SPUP;
        else if (run_s & ~sw_stop & dcp_s & ~(seat_s & door_s))
          next_state = S_SFLT;
      end
      S_SFLT:
        if (panel_off)
          next_state = S_IDLE;
      S_SPUP, S_READY:
      begin
        if (hfail_s)
          next_state = S_HEAD;
        else if (~spon_s | (panel_off & ~wg_s))
          next_state = S_SPDN;
        else if (state == S_SPUP && spun_up)
          next_state = S_READY;
      end
      S_SPDN:
        if (hfail_s)
          next_state = S_HEAD;
        else if (stop_s)
          next_state = S_IDLE;
      S_HEAD:
        next_state = S_HEAD;
      default:
        next_state = S_IDLE;
    endcase
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      state    <= S_IDLE;
      spin_cnt <= 64'd0;
      rest_d   <= 1'b0;
      cmd_d    <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      rest_d <= rest_s;
      cmd_d  <= cmd_s;
      if (state == S_SPUP && next_state == S_SPUP)
        spin_cnt <= spin_cnt + 64'd1;
      else
        spin_cnt <= 64'd0;
    end
  end

  // ----------------------------------------------------------------
  // Fault classes
  // ----------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (rst)
    begin
      c1_flag <= 1'b0;
      c2_flag <= 1'b0;
    end
    else
    begin
      if (spinning & c1_s)
        c1_flag <= 1'b1;
      else if (rest_edge)
        c1_flag <= 1'b0;
      if (spinning & c2_s)
        c2_flag <= 1'b1;
      else if (state == S_SPDN && next_state == S_IDLE)
        c2_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Panel and interface outputs
  // ----------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (rst)
    begin
      ready_led    <= 1'b0;
      fault_led    <= 1'b0;
      door_lock    <= 1'b0;
      spindle_run  <= 1'b0;
      drive_ready  <= 1'b0;
      cmd_accept   <= 1'b0;
      write_enable <= 1'b0;
    end
    else
    begin
      case (state)
        S_SPUP:  ready_led <= blink_slow;
        S_READY: ready_led <= 1'b1;
        S_SPDN:  ready_led <= blink_fast;
        S_HEAD:  ready_led <= blink_slow;
        default: ready_led <= 1'b0;
      endcase
      if (state == S_HEAD || state == S_SFLT || c2_flag)
        fault_led <= blink_slow;
      else
        fault_led <= c1_flag & (state != S_IDLE);
      // Latch holds on a head failure
      door_lock   <= ~(state == S_IDLE || state == S_SFLT);
      spindle_run <= spinning;
      drive_ready <= (state == S_READY);
      cmd_accept  <= cmd_edge & (state == S_READY);
      write_enable <= (state == S_READY) & wg_s &
                      ~(csel_s & cprot_s) & ~(~csel_s & fprot_s);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  wire [`FP_EV_W-1:0] events;
  assign events[`FP_EV_READY]     = (next_state == S_READY) & (state != S_READY);
  assign events[`FP_EV_STOPPED]   = (state == S_SPDN) & (next_state == S_IDLE);
  assign events[`FP_EV_CLASS1]    = spinning & c1_s & ~c1_flag;
  assign events[`FP_EV_CLASS2]    = spinning & c2_s & ~c2_flag;
  assign events[`FP_EV_START_FLT] = (next_state == S_SFLT) & (state != S_SFLT);
  assign events[`FP_EV_HEAD_FAIL] = (next_state == S_HEAD) & (state != S_HEAD);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire       wr_acc = psel & penable & pready & pwrite;
  wire       setup  = psel & ~penable;

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `FP_CTRL_OFS) | (a == `FP_STATE_OFS) |
               (a == `FP_IRQ_STAT_OFS) | (a == `FP_IRQ_EN_OFS) |
               (a == `FP_IRQ_CLR_OFS);
    end
  endfunction

  reg [31:0] next_rdata;
  always @*
  begin
    case (paddr)
      `FP_CTRL_OFS:     next_rdata = {31'h0, sw_stop};
      `FP_STATE_OFS:    next_rdata = {24'h0, c2_flag, c1_flag, state};
      `FP_IRQ_STAT_OFS: next_rdata = {26'h0, irq_stat};
      `FP_IRQ_EN_OFS:   next_rdata = {26'h0, irq_en};
      default:          next_rdata = 32'h0;
    endcase
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      prdata   <= 32'h0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      sw_stop  <= `FP_CTRL_RST;
      irq_en   <= `FP_IRQ_EN_RST;
      irq_stat <= {`FP_EV_W{1'b0}};
      irq      <= 1'b0;
    end
    else
    begin
      // One wait-free access phase after each setup
      pready  <= setup;
      pslverr <= setup & ~mapped(paddr);
      if (setup)
        prdata <= pwrite ? 32'h0 : next_rdata;
      if (wr_acc && paddr == `FP_CTRL_OFS)
        sw_stop <= pwdata[`FP_CTRL_STOP_BIT];
      if (wr_acc && paddr == `FP_IRQ_EN_OFS)
        irq_en <= pwdata[`FP_EV_W-1:0];
      // Set wins over a clear in the same cycle
      if (wr_acc && paddr == `FP_IRQ_CLR_OFS)
        irq_stat <= (irq_stat & ~pwdata[`FP_EV_W-1:0]) | events;
      else
        irq_stat <= irq_stat | events;
      irq <= |(irq_stat & irq_en);
    end
  end

endmodule

// ==== tb/fp_seq_properties.sv ====
// Port checker for the front-panel sequencer.
// Assumes it is bound into the design top and runs on mclk.
`timescale 1ns/1ps
module fp_seq_properties #(
  parameter [63:0] SPINUP_CYCLES = 64'd200
) (
  input wire mclk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire door_closed,
  input wire cart_protect,
  input wire cart_addressed,
  input wire fixed_protect,
  input wire head_retract_fail,
  input wire ready_led,
  input wire door_lock,
  input wire spindle_run,
  input wire drive_ready,
  input wire cmd_accept,
  input wire write_enable
);
  // ----------------------------------------
  // Spin-up length counter
  // ----------------------------------------
  reg [31:0] up_cnt;
  always @(posedge mclk)
  begin
    if (rst || !spindle_run)
      up_cnt <= 32'h0;
    else if (!drive_ready)
      up_cnt <= up_cnt + 32'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_cmd_gated: assert property (cmd_accept |-> drive_ready || $past(drive_ready))
    else $error("command accepted while not ready");
  a_green_steady: assert property (drive_ready |-> ready_led)
    else $error("ready without green");
  a_idle_dark: assert property (!door_lock |-> !ready_led)
    else $error("green lit with door free");
  a_tab_block: assert property ((cart_protect && cart_addressed) [*6] |-> !write_enable)
    else $error("write to protected cartridge");
  a_fixed_block: assert property ((fixed_protect && !cart_addressed) [*6] |-> !write_enable)
    else $error("write to protected fixed volume");
  a_door_spin: assert property ((!door_closed) [*6] |-> !$rose(spindle_run))
    else $error("spin-up with door open");
  a_head_stop: assert property ($rose(head_retract_fail) && door_lock
    |-> ##[1:8] (!spindle_run && door_lock))
    else $error("head failure not handled");
  a_spin_len: assert property ($rose(drive_ready)
    |-> up_cnt + 64'd2 >= SPINUP_CYCLES && up_cnt <= SPINUP_CYCLES + 64'd1)
    else $error("spin-up length wrong");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("apb answer late");
  c_ready: cover property ($rose(drive_ready));
  c_cmd: cover property (cmd_accept);
  c_head: cover property ($rose(head_retract_fail) && door_lock);
endmodule
bind front_panel_status_sequencer fp_seq_properties #(.SPINUP_CYCLES(SPINUP_CYCLES)) i_props (
  .mclk, .rst, .psel, .penable, .pready, .door_closed, .cart_protect, .cart_addressed,
  .fixed_protect, .head_retract_fail, .ready_led, .door_lock, .spindle_run, .drive_ready,
  .cmd_accept, .write_enable);

// ==== tb/fp_ctrl_model.sv ====
// Disk controller model on the drive interface.
// Assumes the bench calls its tasks; levels change after mclk edges.
`timescale 1ns/1ps
module fp_ctrl_model (
  input  wire mclk,
  output reg  spindle_on,
  output reg  write_gate,
  output reg  cart_addressed,
  output reg  restore,
  output reg  cmd_strobe
);
  initial {spindle_on, write_gate, cart_addressed, restore, cmd_strobe} = 5'h00;
  task set_lines(input logic s, input logic w, input logic v);
    @(posedge mclk);
    spindle_on <= s;
    write_gate <= w;
    cart_addressed <= v;
  endtask
  // restore or command
  // Held three cycles so the two-flop sync sees it
  task pulse(input logic rs);
    @(posedge mclk);
    restore <= rs;
    cmd_strobe <= !rs;
    repeat (3) @(posedge mclk);
    restore <= 1'b0;
    cmd_strobe <= 1'b0;
    @(posedge mclk);
  endtask
endmodule

// ==== tb/front_panel_status_sequencer_tb_top.sv ====
// Self-checking bench for the front-panel sequencer.
// Assumes short spin-up and blink parameters; APB master is this bench.
`timescale 1ns/1ps
`include "fp_regs.vh"
module front_panel_status_sequencer_tb_top;
  logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, e;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, r, seed = 32'h50;
  logic        run_sw = 0, cart_seated = 0, door_closed = 0, dc_power = 0, power_safe = 0;
  logic        cart_protect = 0, fixed_protect = 0, spindle_stopped = 0;
  logic        head_retract_fail = 0, class1_fault = 0, class2_fault = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, ready_led, fault_led, door_lock, spindle_run;
  wire         drive_ready, cmd_accept, write_enable;
  wire         spindle_on, write_gate, cart_addressed, restore, cmd_strobe;
  int          n_errors = 0, num_checks = 0, cyc = 0, n_acc = 0, n;
  front_panel_status_sequencer #(.SPINUP_CYCLES(64'd200), .HALF_FAST(26'd4))
    i_front_panel_status_sequencer (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .run_sw, .cart_seated, .door_closed, .dc_power,
    .spindle_on, .power_safe, .write_gate, .cart_protect, .fixed_protect, .cart_addressed,
    .spindle_stopped, .head_retract_fail, .class1_fault, .class2_fault, .restore,
    .cmd_strobe, .ready_led, .fault_led, .door_lock, .spindle_run, .drive_ready,
    .cmd_accept, .write_enable);
  fp_ctrl_model i_fp_ctrl_model (.mclk, .spindle_on, .write_gate, .cart_addressed,
    .restore, .cmd_strobe);
  initial forever #4 mclk = ~mclk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      n_errors++;
    end
  endtask
  task tally_and_finish;
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Held until pready, no assumed latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task tog(input logic red, input int c);
    logic last;
    n = 0;
    last = red ? fault_led : ready_led;
    repeat (c)
    begin
      @(posedge mclk);
      if ((red ? fault_led : ready_led) !== last)
        n++;
      last = red ? fault_led : ready_led;
    end
  endtask
  task wait_ready;
    while (drive_ready !== 1'b1)
      @(posedge mclk);
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cmd_accept === 1'b1)
      n_acc <= n_acc + 1;
    if (cyc == 8000)
    begin
      n_errors++;
      tally_and_finish;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("outs", {door_lock, spindle_run, drive_ready, ready_led, fault_led, irq}, 32'h0);
    apb(0, `FP_CTRL_OFS, 32'h0);
    chk("ctrl", r, 32'h0);
    apb(0, `FP_IRQ_EN_OFS, 32'h0);
    chk("en", r, 32'h0);
    seed = xs(seed);
    apb(1, `FP_IRQ_EN_OFS, seed);
    apb(0, `FP_IRQ_EN_OFS, 32'h0);
    chk("en_rw", r, seed & 32'h3F);
    apb(0, 8'h20, 32'h0);
    chk("slverr", e, 1'b1);
    chk("slv_rdata", r, 32'h0);
    apb(1, `FP_STATE_OFS, 32'hFF);
    apb(0, `FP_STATE_OFS, 32'h0);
    chk("idle", r, 32'h1);
    apb(1, `FP_IRQ_EN_OFS, 32'h3F);
    power_safe <= 1'b1;
    i_fp_ctrl_model.set_lines(1, 0, 0);
    run_sw <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("no_dc", {door_lock, spindle_run, fault_led, irq}, 32'h0);
    dc_power <= 1'b1;
    i_fp_ctrl_model.pulse(0);
    repeat (6) @(posedge mclk);
    chk("nospin", {spindle_run, ready_led}, 32'h0);
    tog(1, 64);
    chk("red_slow", n >= 7 && n <= 9, 1);
    chk("irq_on", irq, 1);
    apb(1, `FP_IRQ_CLR_OFS, 32'h3F);
    repeat (3) @(posedge mclk);
    chk("irq_clr", irq, 0);
    run_sw <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("dark", {door_lock, ready_led, fault_led}, 32'h0);
    cart_seated <= 1'b1;
    door_closed <= 1'b1;
    power_safe <= 1'b0;
    run_sw <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("no_psafe", {spindle_run, door_lock, fault_led}, 32'h0);
    power_safe <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("spin", {spindle_run, door_lock}, 32'h3);
    tog(0, 64);
    chk("green_slow", n >= 7 && n <= 9, 1);
    wait_ready;
    tog(0, 16);
    chk("green_on", {drive_ready, ready_led, n[3:0]}, 32'h30);
    chk("acc_early", n_acc, 0);
    i_fp_ctrl_model.pulse(0);
    repeat (4) @(posedge mclk);
    chk("acc", n_acc, 1);
    chk("irq_rdy", irq, 1);
    apb(1, `FP_IRQ_EN_OFS, 32'h0);
    repeat (3) @(posedge mclk);
    chk("irq_mask", irq, 0);
    apb(1, `FP_IRQ_CLR_OFS, 32'h3F);
    apb(1, `FP_IRQ_EN_OFS, 32'h3F);
    for (int i = 0; i < 8; i++)
    begin
      cart_protect <= i[0];
      fixed_protect <= i[1];
      i_fp_ctrl_model.set_lines(1, 1, i[2]);
      seed = xs(seed);
      repeat (6 + seed[1:0]) @(posedge mclk);
      chk("wr_en", write_enable, i[2] ? !i[0] : !i[1]);
    end
    i_fp_ctrl_model.set_lines(1, 0, 0);
    class1_fault <= 1'b1;
    repeat (3) @(posedge mclk);
    class1_fault <= 1'b0;
    repeat (3) @(posedge mclk);
    tog(1, 32);
    chk("red_on", {fault_led, n[3:0]}, 32'h10);
    i_fp_ctrl_model.pulse(1);
    repeat (4) @(posedge mclk);
    chk("restore", fault_led, 0);
    class2_fault <= 1'b1;
    repeat (3) @(posedge mclk);
    class2_fault <= 1'b0;
    i_fp_ctrl_model.pulse(1);
    tog(1, 64);
    chk("red_blink", n >= 7 && n <= 9, 1);
    i_fp_ctrl_model.set_lines(1, 1, 0);
    run_sw <= 1'b0;
    repeat (12) @(posedge mclk);
    chk("wg_hold", spindle_run, 1);
    i_fp_ctrl_model.set_lines(1, 0, 0);
    repeat (6) @(posedge mclk);
    chk("stop", {spindle_run, door_lock}, 32'h1);
    tog(0, 64);
    chk("green_fast", n >= 15 && n <= 17, 1);
    spindle_stopped <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("off", {door_lock, ready_led, fault_led}, 32'h0);
    spindle_stopped <= 1'b0;
    apb(1, `FP_CTRL_OFS, 32'h1);
    run_sw <= 1'b1;
    repeat (8) @(posedge mclk);
    apb(0, `FP_CTRL_OFS, 32'h0);
    chk("sw_stop", {r[0], spindle_run, door_lock}, 32'h4);
    apb(1, `FP_CTRL_OFS, 32'h0);
    wait_ready;
    i_fp_ctrl_model.set_lines(0, 0, 0);
    repeat (6) @(posedge mclk);
    chk("sp_drop", {spindle_run, door_lock}, 32'h1);
    head_retract_fail <= 1'b1;
    spindle_stopped <= 1'b1;
    repeat (8) @(posedge mclk);
    apb(0, `FP_STATE_OFS, 32'h0);
    chk("head", {r[5:0], spindle_run, door_lock}, 32'h81);
    tog(0, 64);
    chk("hf_green", n >= 7 && n <= 9, 1);
    tog(1, 64);
    chk("hf_red", n >= 7 && n <= 9, 1);
    tally_and_finish;
  end
endmodule
